// [plt_pkg.sv]
// constants, enumerations and command layout shared by the loopback tester
package plt_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_DET = 8'h0C;
  localparam logic [7:0] A_INJ = 8'h10;
  localparam logic [7:0] A_BITS = 8'h14;
  localparam logic [7:0] A_CYC = 8'h18;
  localparam logic [7:0] A_TXW = 8'h1C;
  localparam logic [7:0] A_RXW = 8'h20;
  localparam logic [7:0] A_IST = 8'h24;
  localparam logic [7:0] A_ICLR = 8'h28;
  localparam logic [7:0] A_IEN = 8'h2C;
  localparam logic [1:0] A_LANE_HI = 2'h1;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CFG_LOOP_LSB = 8;
  localparam int ST_RUN = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_SYNC = 2;
  localparam int ST_LK_LSB = 8;
  localparam int ST_SY_LSB = 16;
  localparam int IRQ_W = 3;
  localparam int IRQ_ERR = 0;
  localparam int IRQ_SLOSS = 1;
  localparam int IRQ_LLOSS = 2;
  localparam logic [30:0] GEN_SEED = 31'h7FFFFFFF;
  localparam logic [5:0] LF_HIGH = 6'h11;
  localparam logic [5:0] LF_LAST = 6'h20;
  localparam logic [3:0] SYNC_WORDS = 4'h8;
  localparam logic [7:0] LOSS_BITS = 8'h04;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {M_PRBS7, M_PRBS15, M_PRBS23, M_PRBS31, M_HF, M_LF} plt_mode_e;
  typedef enum logic {S_IDLE, S_RUN} plt_state_e;
  typedef struct packed {
    logic insert;
    logic clear;
    logic stop;
    logic start;
  } plt_cmd_s;

endpackage

// [plt_tester.sv]
// multi-lane pattern generator and checker with apb control registers
module plt_tester #(
  parameter int NL = 4,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NL-1:0][DW-1:0] rx_data,
  input wire logic [NL-1:0] rx_valid,
  input wire logic [NL-1:0] pll_locked,
  output logic [NL-1:0][DW-1:0] tx_data,
  output logic tx_valid,
  output logic [NL-1:0] serial_loopback,
  output logic irq
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    plt_pkg::plt_state_e st;
    plt_pkg::plt_mode_e mode;
    logic [NL-1:0] loop;
    logic [30:0] gen;
    logic [5:0] ph;
    logic [NL-1:0][DW-1:0] tx;
    logic txv;
    logic [NL-1:0][DW-1:0] rx1;
    logic [NL-1:0][DW-1:0] rx2;
    logic [NL-1:0] rv1;
    logic [NL-1:0] rv2;
    logic [NL-1:0] lk1;
    logic [NL-1:0] lk2;
    logic [NL-1:0] lk3;
    logic [NL-1:0][30:0] hist;
    logic [NL-1:0][5:0] rc;
    logic [NL-1:0][3:0] good;
    logic [NL-1:0] sync;
    logic [NL-1:0][15:0] lerr;
    logic [31:0] det;
    logic [31:0] inj;
    logic [31:0] bits;
    logic [31:0] cyc;
    logic [31:0] txw;
    logic [31:0] rxw;
    logic [plt_pkg::IRQ_W-1:0] ist;
    logic [plt_pkg::IRQ_W-1:0] ien;
    logic irq;
    logic rdy;
    logic err;
    logic [31:0] rd;
  } plt_st_s;

  plt_st_s s_reg;
  plt_st_s s_next;
  plt_pkg::plt_cmd_s cmd;
  logic wr;

  // predicted next bit from the last 31 bits, newest in bit 0
  function automatic logic prbs_fb(input logic [30:0] h, input plt_pkg::plt_mode_e m);
    case (m)
      plt_pkg::M_PRBS7: prbs_fb = h[6] ^ h[5];
      plt_pkg::M_PRBS15: prbs_fb = h[14] ^ h[13];
      plt_pkg::M_PRBS23: prbs_fb = h[22] ^ h[17];
      default: prbs_fb = h[30] ^ h[27];
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [DW-1:0] w;
    logic [DW-1:0] d;
    logic [30:0] h;
    logic [5:0] r;
    logic [5:0] p;
    logic pred;
    logic v;
    logic [7:0] ne;
    logic [31:0] dsum;
    logic [31:0] bsum;
    logic [31:0] rsum;
    logic [plt_pkg::IRQ_W-1:0] ev;
    logic [31:0] rdat;
    logic hit;
    logic [3:0] li;
    w = '0;
    d = '0;
    h = '0;
    r = '0;
    p = '0;
    pred = 1'b0;
    v = 1'b0;
    ne = '0;
    dsum = '0;
    bsum = '0;
    rsum = '0;
    ev = '0;
    rdat = '0;
    hit = 1'b1;
    li = paddr[5:2];
    s_next = s_reg;
    wr = psel & penable & s_reg.rdy & pwrite;
    cmd = '0;
    if (wr && paddr == plt_pkg::A_CMD)
      cmd = plt_pkg::plt_cmd_s'(pwdata[3:0]);

    // pin inputs pass two flops before use
    s_next.rx1 = rx_data;
    s_next.rx2 = s_reg.rx1;
    s_next.rv1 = rx_valid;
    s_next.rv2 = s_reg.rv1;
    s_next.lk1 = pll_locked;
    s_next.lk2 = s_reg.lk1;
    s_next.lk3 = s_reg.lk2;

    // run control; stop wins if both come in one write
    if (cmd.start)
    begin
      s_next.st = plt_pkg::S_RUN;
      s_next.gen = plt_pkg::GEN_SEED; // a short sequence could otherwise inherit all-zero low bits and stick
      s_next.ph = '0;
      s_next.good = '0;
      s_next.sync = '0;
    end
    if (cmd.stop)
      s_next.st = plt_pkg::S_IDLE;

    // pattern generator, bit 0 of a word goes out first
    s_next.txv = (s_reg.st == plt_pkg::S_RUN);
    s_next.tx = '0;
    if (s_reg.st == plt_pkg::S_RUN)
    begin
      h = s_reg.gen;
      p = s_reg.ph;
      for (int i = 0; i < DW; i++)
      begin
        case (s_reg.mode)
          plt_pkg::M_HF:
          begin
            w[i] = ~p[0];
            p = p ^ 6'h01;
          end
          plt_pkg::M_LF:
          begin
            w[i] = (p < plt_pkg::LF_HIGH);
            p = (p == plt_pkg::LF_LAST) ? 6'h00 : p + 6'h01;
          end
          default:
          begin
            w[i] = prbs_fb(h, s_reg.mode);
            h = {h[29:0], w[i]};
          end
        endcase
      end
      s_next.gen = h;
      s_next.ph = p;
      for (int l = 0; l < NL; l++)
        s_next.tx[l] = w;
      // only accepted while running; one word on lane 0 is hit
      if (cmd.insert)
      begin
        s_next.tx[0][0] = ~w[0];
        s_next.inj = s_reg.inj + 32'h1;
      end
      s_next.cyc = s_reg.cyc + 32'h1;
      s_next.txw = s_reg.txw + 32'(NL);
    end

    // self-seeding checker per lane
    for (int l = 0; l < NL; l++)
    begin
      d = s_reg.loop[l] ? s_reg.tx[l] : s_reg.rx2[l];
      v = s_reg.loop[l] ? s_reg.txv : s_reg.rv2[l];
      if (s_reg.st == plt_pkg::S_RUN && v)
      begin
        h = s_reg.hist[l];
        r = s_reg.rc[l];
        ne = '0;
        rsum = rsum + 32'h1;
        for (int i = 0; i < DW; i++)
        begin
          case (s_reg.mode)
            plt_pkg::M_HF: pred = ~h[0];
            plt_pkg::M_LF: pred = ((h[0] && r == plt_pkg::LF_HIGH) || (!h[0] && r == 6'h10)) ? ~h[0] : h[0];
            default: pred = prbs_fb(h, s_reg.mode);
          endcase
          ne = ne + {7'h00, d[i] ^ pred};
          r = (d[i] == h[0]) ? r + 6'h01 : 6'h01;
          h = {h[29:0], d[i]};
        end
        s_next.hist[l] = h;
        s_next.rc[l] = r;
        if (s_reg.sync[l])
        begin
          dsum = dsum + {24'h0, ne};
          s_next.lerr[l] = s_reg.lerr[l] + {8'h00, ne};
          bsum = bsum + 32'(DW);
          if (ne > plt_pkg::LOSS_BITS)
          begin
            s_next.sync[l] = 1'b0;
            s_next.good[l] = '0;
            ev[plt_pkg::IRQ_SLOSS] = 1'b1;
          end
        end
        else if (ne == 8'h00)
        begin
          s_next.good[l] = s_reg.good[l] + 4'h1;
          if (s_reg.good[l] == plt_pkg::SYNC_WORDS - 4'h1)
            s_next.sync[l] = 1'b1;
        end
        else
          s_next.good[l] = '0;
      end
    end
    s_next.det = s_reg.det + dsum;
    s_next.bits = s_reg.bits + bsum;
    s_next.rxw = s_reg.rxw + rsum;
    ev[plt_pkg::IRQ_ERR] = (dsum != 32'h0);
    ev[plt_pkg::IRQ_LLOSS] = |(s_reg.lk3 & ~s_reg.lk2);

    // clear zeroes all run counters
    if (cmd.clear)
    begin
      s_next.det = '0;
      s_next.inj = '0;
      s_next.lerr = '0;
      s_next.bits = '0;
      s_next.cyc = '0;
      s_next.txw = '0;
      s_next.rxw = '0;
    end

    // register writes
    if (wr && paddr == plt_pkg::A_CFG)
    begin
      s_next.mode = plt_pkg::plt_mode_e'(pwdata[2:0]);
      s_next.loop = pwdata[plt_pkg::CFG_LOOP_LSB +: NL];
    end
    if (wr && paddr == plt_pkg::A_IEN)
      s_next.ien = pwdata[plt_pkg::IRQ_W-1:0];
    // a new event wins over a clear in the same cycle
    s_next.ist = s_reg.ist;
    if (wr && paddr == plt_pkg::A_ICLR)
      s_next.ist = s_reg.ist & ~pwdata[plt_pkg::IRQ_W-1:0];
    s_next.ist = s_next.ist | ev;
    s_next.irq = |(s_next.ist & s_next.ien);

    // read mux, answered one cycle after setup
    case (paddr)
      plt_pkg::A_CMD: rdat = '0;
      plt_pkg::A_CFG: rdat = {16'h0, 8'(s_reg.loop), 5'h00, s_reg.mode};
      plt_pkg::A_STAT:
      begin
        rdat[plt_pkg::ST_RUN] = (s_reg.st == plt_pkg::S_RUN);
        rdat[plt_pkg::ST_LOCK] = &s_reg.lk2;
        rdat[plt_pkg::ST_SYNC] = &s_reg.sync;
        rdat[plt_pkg::ST_LK_LSB +: NL] = s_reg.lk2;
        rdat[plt_pkg::ST_SY_LSB +: NL] = s_reg.sync;
      end
      plt_pkg::A_DET: rdat = s_reg.det;
      plt_pkg::A_INJ: rdat = s_reg.inj;
      plt_pkg::A_BITS: rdat = s_reg.bits;
      plt_pkg::A_CYC: rdat = s_reg.cyc;
      plt_pkg::A_TXW: rdat = s_reg.txw;
      plt_pkg::A_RXW: rdat = s_reg.rxw;
      plt_pkg::A_IST: rdat = {29'h0, s_reg.ist};
      plt_pkg::A_ICLR: rdat = '0;
      plt_pkg::A_IEN: rdat = {29'h0, s_reg.ien};
      default:
      begin
        hit = (paddr[7:6] == plt_pkg::A_LANE_HI) && (32'(li) < NL);
        if (hit)
          rdat = {16'h0, s_reg.lerr[li]};
      end
    endcase
    s_next.rdy = psel & ~penable;
    s_next.err = psel & ~penable & ~hit;
    s_next.rd = (psel & ~penable & ~pwrite & hit) ? rdat : '0;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
      s_reg.mode <= plt_pkg::M_PRBS31;
      s_reg.gen <= plt_pkg::GEN_SEED;
    end
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign prdata = s_reg.rd;
  assign pready = s_reg.rdy;
  assign pslverr = s_reg.err;
  assign tx_data = s_reg.tx;
  assign tx_valid = s_reg.txv;
  assign serial_loopback = s_reg.loop;
  assign irq = s_reg.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_INSERT: assert property (wr && paddr == plt_pkg::A_CMD && pwdata[3] && !pwdata[2] && s_reg.st == plt_pkg::S_RUN
    |=> s_reg.inj == $past(s_reg.inj) + 32'h1 && s_reg.tx[0][0] != s_reg.tx[NL-1][0]) else $error("insert not applied");
  AST_INS_IDLE: assert property (wr && paddr == plt_pkg::A_CMD && !pwdata[2] && s_reg.st == plt_pkg::S_IDLE
    |=> $stable(s_reg.inj)) else $error("insert taken while idle");
  AST_CLEAR: assert property (wr && paddr == plt_pkg::A_CMD && pwdata[2]
    |=> s_reg.det == 32'h0 && s_reg.inj == 32'h0) else $error("clear left counters");
  AST_START: assert property (wr && paddr == plt_pkg::A_CMD && pwdata[0] && !pwdata[1]
    |=> s_reg.st == plt_pkg::S_RUN ##1 tx_valid) else $error("start did not run");
  AST_STOP: assert property (wr && paddr == plt_pkg::A_CMD && pwdata[1] && !pwdata[2]
    |=> s_reg.st == plt_pkg::S_IDLE ##1 !tx_valid && $stable(s_reg.det)) else $error("stop failed");
  AST_HF: assert property (s_reg.st == plt_pkg::S_RUN && s_reg.mode == plt_pkg::M_HF
    |=> tx_data[NL-1][0] != tx_data[NL-1][1]) else $error("hf pattern wrong");
  AST_PRBS7: assert property (s_reg.st == plt_pkg::S_RUN && s_reg.mode == plt_pkg::M_PRBS7
    |=> tx_data[NL-1][7] == (tx_data[NL-1][0] ^ tx_data[NL-1][1])) else $error("prbs7 recurrence broken");
  AST_SYNC: assert property (!s_reg.sync[0] && s_reg.good[0] < plt_pkg::SYNC_WORDS - 4'h1
    |=> !s_reg.sync[0]) else $error("sync declared early");
  AST_BITS: assert property (s_reg.sync == '0 && !(wr && paddr == plt_pkg::A_CMD)
    |=> $stable(s_reg.bits)) else $error("bits counted without sync");
  AST_APB: assert property (psel && !penable |=> pready ##1 !pready) else $error("apb answer timing");
  AST_INJ_HOLD: assert property (!(wr && paddr == plt_pkg::A_CMD)
    |=> $stable(s_reg.inj)) else $error("injected count moved without a command");
  AST_TX_IDLE: assert property (s_reg.st == plt_pkg::S_IDLE
    |=> tx_data == '0 && !tx_valid) else $error("transmit active while stopped");

  CV_START: cover property (wr && paddr == plt_pkg::A_CMD && pwdata[0]);
  CV_INSERT: cover property (s_reg.st == plt_pkg::S_RUN && wr && paddr == plt_pkg::A_CMD && pwdata[3]);
  CV_SYNC: cover property ($rose(s_reg.sync[0]));
  CV_IRQ: cover property ($rose(irq));

endmodule

// [plt_far_end.sv]
// far-end model: echoes each lane's transmit word, with optional extra latency and a commanded flip of bit 0 on lane 1
module plt_far_end #(
  parameter int NL = 4,
  parameter int DW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NL-1:0][DW-1:0] tx_data,
  input wire logic tx_valid,
  input wire logic slow,
  input wire logic flip_now,
  output logic [NL-1:0][DW-1:0] rx_data,
  output logic [NL-1:0] rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0][NL-1:0][DW-1:0] dq;
  logic [2:0] vq;
  logic [NL-1:0][DW-1:0] last;
  logic [NL-1:0][DW-1:0] tap;
  logic vt;
  // three-word pipe; slow picks the deep tap and is only changed between runs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq <= '0;
      vq <= '0;
      last <= '0;
    end
    else
    begin
      dq <= {dq[1:0], tx_data ^ ((NL*DW)'(flip_now) << DW)};
      vq <= {vq[1:0], tx_valid};
      if (vt)
        last <= tap;
    end
  end
  // a released line shows the inverse of its last word, never a stale copy
  assign tap = slow ? dq[2] : dq[0];
  assign vt = slow ? vq[2] : vq[0];
  assign rx_valid = {NL{vt}};
  assign rx_data = vt ? tap : ~last;
endmodule

// [prbs_loopback_tester_tb.sv]
// self-checking bench for the loopback tester: apb master, pattern model and far-end echo
module prbs_loopback_tester_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NL = 4;
  localparam int DW = 8;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, flip_now = 0, er;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic [NL-1:0] pll_locked = '1, rx_valid, serial_loopback;
  logic [NL-1:0][DW-1:0] tx_data, rx_data;
  logic pready, pslverr, tx_valid, irq;
  int mismatches = 0, samples_checked = 0, n, e, m, det_m, lat;
  logic b[$];
  int lag[4] = '{7, 15, 23, 31};
  int tap[4] = '{6, 14, 18, 28};

  always #12.5 pclk = ~pclk;

  plt_tester plt_tester_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_data, .rx_valid, .pll_locked, .tx_data, .tx_valid, .serial_loopback, .irq);
  plt_far_end plt_far_end_i (.pclk, .presetn, .tx_data, .tx_valid, .slow, .flip_now, .rx_data, .rx_valid);

  task complete_run;
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    chk(rd, exp);
  endtask

  task wait_c(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // collect lane 0's serial stream, bit 0 first, and test it against the selected pattern
  task pat(input int md);
    int i, k, bad;
    logic x;
    b.delete();
    for (i = 0; i < 40 && b.size() < 96; i++)
    begin
      @(posedge pclk);
      if (tx_valid === 1'b1)
        for (k = 0; k < DW; k++)
          b.push_back(tx_data[0][k]);
    end
    bad = 0;
    for (k = 0; k < b.size(); k++)
    begin
      if (md < 4)
        x = (k >= lag[md]) ? b[k-lag[md]] ^ b[k-tap[md]] : b[k];
      else
        x = (md == 4) ? (k % 2 == 0) : (k % 33 < 17);
      bad += (b[k] !== x);
    end
    chk(bad, 0);
    chk(b.size(), 96);
  endtask

  initial
  begin
    void'($urandom(32'h9C01));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rdchk(plt_pkg::A_CFG, 32'h3);
    apb(1, plt_pkg::A_CMD, 32'h8);
    rdchk(plt_pkg::A_INJ, 0);
    apb(0, 8'h30, 0);
    chk({rd[30:0], er}, 32'h1);
    n = $urandom_range(15, 1);
    apb(1, plt_pkg::A_CFG, (n << plt_pkg::CFG_LOOP_LSB) | 3);
    rdchk(plt_pkg::A_CFG, (n << plt_pkg::CFG_LOOP_LSB) | 3);
    chk(serial_loopback, n);
    apb(1, plt_pkg::A_CFG, 32'h3);
    apb(1, plt_pkg::A_IEN, 32'h1);
    for (m = 0; m < 6; m++)
    begin
      slow <= m[0];
      det_m = 0;
      // the later modes also loop lanes 2 and 3 back internally
      apb(1, plt_pkg::A_CFG, m | ((m >= 3) ? (32'hC << plt_pkg::CFG_LOOP_LSB) : 0));
      apb(1, plt_pkg::A_CMD, 32'h4);
      apb(1, plt_pkg::A_CMD, 32'h1);
      pat(m);
      wait_c(20);
      rdchk(plt_pkg::A_STAT, 32'h000F0F07);
      // all lanes synced: compared bits grow by one word per lane per cycle, three cycles between reads
      apb(0, plt_pkg::A_BITS, 0);
      n = rd;
      rdchk(plt_pkg::A_BITS, n + 3 * NL * DW);
      if (m < 5)
      begin
        e = (m == 4) ? 2 : 3;
        n = $urandom_range(3, 1);
        repeat (n)
        begin
          apb(1, plt_pkg::A_CMD, 32'h8);
          wait_c(20);
        end
        flip_now <= 1;
        @(posedge pclk);
        flip_now <= 0;
        wait_c(20);
        det_m = e * (n + 1);
        rdchk(plt_pkg::A_INJ, n);
        rdchk(plt_pkg::A_DET, det_m);
        rdchk(8'h40, e * n);
        rdchk(8'h44, e);
        chk(irq, 1);
        apb(1, plt_pkg::A_ICLR, 32'h7);
        wait_c(2);
        chk(irq, 0);
      end
      apb(1, plt_pkg::A_CMD, 32'h2);
      wait_c(4);
      chk(tx_valid, 0);
      rdchk(plt_pkg::A_DET, det_m);
      apb(0, plt_pkg::A_CYC, 0);
      n = rd;
      rdchk(plt_pkg::A_TXW, NL * n);
      // far-end lanes lose the words still in the echo pipe and input flops at stop, looped lanes only one
      lat = m[0] ? 6 : 4;
      rdchk(plt_pkg::A_RXW, (m >= 3) ? (NL - 2) * (n - lat) + 2 * (n - 1) : NL * (n - lat));
    end
    apb(1, plt_pkg::A_CMD, 32'h4);
    rdchk(plt_pkg::A_DET, 0);
    rdchk(plt_pkg::A_INJ, 0);
    // lock loss is logged but masked from the interrupt line
    apb(1, plt_pkg::A_IEN, 32'h3);
    pll_locked <= 4'hB;
    wait_c(6);
    apb(0, plt_pkg::A_STAT, 0);
    chk(rd & 32'h00000F03, 32'h00000B00);
    apb(0, plt_pkg::A_IST, 0);
    chk(rd[2], 1);
    chk(irq, 0);
    complete_run();
  end

  // watchdog well beyond the longest sequence
  initial
  begin
    #2500000;
    mismatches++;
    complete_run();
  end
endmodule
